// ---- shared/sic_pkg.sv ----
// package for the serial interface mode configuration block
// assumes a single aclk domain and an AXI4-Lite register path
package sic_pkg;
    // register byte offsets
    localparam logic [7:0] SIC_OFF_MODE     = 8'h00;
    localparam logic [7:0] SIC_OFF_STATUS   = 8'h04;
    localparam logic [7:0] SIC_OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] SIC_OFF_IRQ_CLR  = 8'h0c;
    localparam logic [7:0] SIC_OFF_IRQ_EN   = 8'h10;
    // mode register field positions
    localparam int SIC_POS_CRC_TYPE  = 11;
    localparam int SIC_POS_RESET     = 10;
    localparam int SIC_POS_WSIZE     = 8;
    localparam int SIC_POS_RSVD      = 5;
    localparam int SIC_POS_TIMEOUT   = 4;
    // mode register reset values
    localparam logic       SIC_RST_CRC_TYPE = 1'b0;
    localparam logic       SIC_RST_RESET    = 1'b1;
    localparam logic [1:0] SIC_RST_WSIZE    = 2'h1;
    localparam logic [2:0] SIC_RST_RSVD     = 3'h0;
    localparam logic       SIC_RST_TIMEOUT  = 1'b1;
    // word size codes
    localparam logic [1:0] SIC_WS_16    = 2'h0;
    localparam logic [1:0] SIC_WS_24    = 2'h1;
    localparam logic [1:0] SIC_WS_32PAD = 2'h2;
    localparam logic [1:0] SIC_WS_32SGN = 2'h3;
    // checksum polynomials
    localparam logic [15:0] SIC_POLY_CCITT = 16'h1021;
    localparam logic [15:0] SIC_POLY_ANSI  = 16'h8005;
    // interrupt event bits
    localparam int SIC_EV_RESET = 0;
    localparam int SIC_EV_WSIZE = 1;
    localparam int SIC_EV_W     = 2;
    // bus answers
    localparam logic [1:0] SIC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] SIC_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       crc_ansi;
        logic       reset_seen;
        logic [1:0] word_size;
        logic       timeout_en;
    } sic_mode_s;

    typedef struct packed {
        logic [31:0] data;
        logic [5:0]  bits;
    } sic_word_s;

    // frame word length in bits for a word size code
    function automatic logic [5:0] sic_word_bits(input logic [1:0] ws);
        case (ws)
            SIC_WS_16: sic_word_bits = 6'h10;
            SIC_WS_24: sic_word_bits = 6'h18;
            default:   sic_word_bits = 6'h20;
        endcase
    endfunction
endpackage

// ---- design/sic_word_fmt.sv ----
// formats a 24-bit converted value into one serial data word
// assumes word_size is stable from the mode register on the same clock
`timescale 1ns/1ps
`default_nettype none
module sic_word_fmt
    import sic_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [1:0]  word_size,
    input  wire logic [23:0] sample,
    input  wire logic        sample_valid,
    output sic_word_s        word_reg,
    output logic             word_valid_reg
);
    // shape the value per word size; register for a clean output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            word_reg       <= '0;
            word_valid_reg <= 1'b0;
        end else begin
            word_valid_reg <= sample_valid;
            if (sample_valid) begin
                word_reg.bits <= sic_word_bits(word_size);
                case (word_size)
                    SIC_WS_16:    word_reg.data <= {16'h0000, sample[23:8]};
                    SIC_WS_24:    word_reg.data <= {8'h00, sample};
                    SIC_WS_32PAD: word_reg.data <= {sample, 8'h00};
                    SIC_WS_32SGN: word_reg.data <= {{8{sample[23]}}, sample};
                    default:      word_reg.data <= '0;
                endcase
            end
        end
    end

    property p_zero_pad;
        @(posedge aclk) disable iff (!aresetn)
        sample_valid && word_size == SIC_WS_32PAD |=>
            word_reg.data == {$past(sample), 8'h00} && word_reg.bits == 6'h20;
    endproperty
    a_zero_pad: assert property (p_zero_pad) else $error("zero padding wrong");

    property p_sign_ext;
        @(posedge aclk) disable iff (!aresetn)
        sample_valid && word_size == SIC_WS_32SGN |=>
            word_reg.data[31:24] == {8{$past(sample[23])}} && word_reg.data[23:0] == $past(sample);
    endproperty
    a_sign_ext: assert property (p_sign_ext) else $error("sign extension wrong");

    property p_word16;
        @(posedge aclk) disable iff (!aresetn)
        sample_valid && word_size == SIC_WS_16 |=> word_reg.bits == 6'h10 && word_reg.data[31:16] == 16'h0000;
    endproperty
    a_word16: assert property (p_word16) else $error("16-bit word wrong");

    c_pad: cover property (@(posedge aclk) disable iff (!aresetn) sample_valid && word_size == SIC_WS_32PAD);
endmodule
`default_nettype wire

// ---- design/sic_mode_regs.sv ----
// serial interface mode register with AXI4-Lite access and interrupt logic
// assumes one aclk domain, synchronous active-low reset, 32-bit bus data
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - bit 11 picks the serial checksum polynomial, 0 for CCITT at reset and 1 for ANSI.
// - bit 10 reads 1 after every reset, stays until software writes 0, and shows in status.
// - bits 9:8 set the word length, 00 for 16 bits and 01 for 24 bits at reset.
// - code 10 sends 32-bit words with the value on top and zero padding below.
// - code 11 sends 32-bit words whose top extra bits copy the value's sign.
module sic_mode_regs
    import sic_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [23:0]       sample,
    input  wire logic              sample_valid,
    output logic [15:0]            crc_poly_reg,
    output logic                   timeout_en_reg,
    output logic [1:0]             word_size_select_reg,
    output logic [5:0]             frame_word_bits_reg,
    output sic_word_s              word_reg,
    output logic                   word_valid_reg,
    output logic                   irq_reg
);
    sic_mode_s         mode_reg;
    logic [2:0]        irq_stat_reg;
    logic [2:0]        irq_en_reg;
    logic [ADDR_W-1:0] waddr_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;
    logic              aw_full_reg;
    logic              w_full_reg;
    logic              do_write;
    logic              first_reg;
    logic [2:0]        ev_set;
    logic [2:0]        clr_bits;
    logic [1:0]        ws_next;

    // mode register viewed as a 16-bit word; reserved bits always read zero
    function automatic logic [15:0] mode_word(input sic_mode_s m);
        logic [15:0] w;
        w = '0;
        w[SIC_POS_CRC_TYPE]          = m.crc_ansi;
        w[SIC_POS_RESET]             = m.reset_seen;
        w[SIC_POS_WSIZE+:2]          = m.word_size;
        w[SIC_POS_RSVD+:3]           = SIC_RST_RSVD;
        w[SIC_POS_TIMEOUT]           = m.timeout_en;
        mode_word = w;
    endfunction

    // write channel capture; address and data may come in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg   <= 1'b0;
            w_full_reg    <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            waddr_reg     <= '0;
            wdata_reg     <= '0;
            wstrb_reg     <= '0;
        end else begin
            s_axi_awready <= !aw_full_reg && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_full_reg && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                waddr_reg   <= s_axi_awaddr;
            end else if (do_write) begin
                aw_full_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end else if (do_write) begin
                w_full_reg <= 1'b0;
            end
        end
    end

    // one write at a time: commit only once the previous response is gone
    assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= SIC_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            case (waddr_reg)
                SIC_OFF_MODE, SIC_OFF_IRQ_CLR, SIC_OFF_IRQ_EN: s_axi_bresp <= SIC_RESP_OKAY;
                default:                                       s_axi_bresp <= SIC_RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // mode register; byte lane 1 holds bits 15:8, lane 0 holds bits 7:0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg.crc_ansi   <= SIC_RST_CRC_TYPE;
            mode_reg.reset_seen <= SIC_RST_RESET;
            mode_reg.word_size  <= SIC_RST_WSIZE;
            mode_reg.timeout_en <= SIC_RST_TIMEOUT;
        end else if (do_write && waddr_reg == SIC_OFF_MODE) begin
            if (wstrb_reg[1]) begin
                mode_reg.crc_ansi <= wdata_reg[SIC_POS_CRC_TYPE];
                // only a written zero clears; writing one leaves it as is
                if (!wdata_reg[SIC_POS_RESET])
                    mode_reg.reset_seen <= 1'b0;
                mode_reg.word_size <= wdata_reg[SIC_POS_WSIZE+:2];
            end
            // reserved bits 7:5 are not stored, so a stray one never sticks
            if (wstrb_reg[0])
                mode_reg.timeout_en <= wdata_reg[SIC_POS_TIMEOUT];
        end
    end

    // marks the first cycle out of reset so the reset event is posted once
    always_ff @(posedge aclk) begin
        if (!aresetn)
            first_reg <= 1'b1;
        else
            first_reg <= 1'b0;
    end

    // events and write-one-to-clear terms for the interrupt status
    always_comb begin
        ws_next  = wdata_reg[SIC_POS_WSIZE+:2];
        ev_set   = '0;
        clr_bits = '0;
        ev_set[SIC_EV_RESET] = first_reg;
        ev_set[SIC_EV_WSIZE] = do_write && waddr_reg == SIC_OFF_MODE && wstrb_reg[1]
                               && ws_next != mode_reg.word_size;
        ev_set[SIC_EV_W]     = word_valid_reg;
        if (do_write && waddr_reg == SIC_OFF_IRQ_CLR && wstrb_reg[0])
            clr_bits = wdata_reg[2:0];
    end

    // sticky status: a new event wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= '0;
            irq_en_reg   <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~clr_bits) | ev_set;
            if (do_write && waddr_reg == SIC_OFF_IRQ_EN && wstrb_reg[0])
                irq_en_reg <= wdata_reg[2:0];
        end
    end

    // interrupt level, registered so the pin never glitches
    always_ff @(posedge aclk) begin
        if (!aresetn)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(((irq_stat_reg & ~clr_bits) | ev_set) & irq_en_reg);
    end

    // read channel: one read in flight, answer one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= SIC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= SIC_RESP_OKAY;
                case (s_axi_araddr)
                    SIC_OFF_MODE:     s_axi_rdata <= {16'h0000, mode_word(mode_reg)};
                    // status mirrors the reset flag in bit 3, next to the other mode fields
                    SIC_OFF_STATUS:   s_axi_rdata <= {27'h0, mode_reg};
                    SIC_OFF_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat_reg};
                    SIC_OFF_IRQ_EN:   s_axi_rdata <= {29'h0, irq_en_reg};
                    SIC_OFF_IRQ_CLR:  s_axi_rdata <= '0;
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= SIC_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // settings that steer the serial framing logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            crc_poly_reg         <= SIC_POLY_CCITT;
            timeout_en_reg       <= SIC_RST_TIMEOUT;
            word_size_select_reg <= SIC_RST_WSIZE;
            frame_word_bits_reg  <= sic_word_bits(SIC_RST_WSIZE);
        end else begin
            crc_poly_reg         <= mode_reg.crc_ansi ? SIC_POLY_ANSI : SIC_POLY_CCITT;
            timeout_en_reg       <= mode_reg.timeout_en;
            word_size_select_reg <= mode_reg.word_size;
            frame_word_bits_reg  <= sic_word_bits(mode_reg.word_size);
        end
    end

    // data word shaping follows the live word size
    sic_word_fmt u_fmt (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .word_size      (mode_reg.word_size),
        .sample         (sample),
        .sample_valid   (sample_valid),
        .word_reg       (word_reg),
        .word_valid_reg (word_valid_reg)
    );

    property p_crc_sel;
        @(posedge aclk) disable iff (!aresetn)
        ##1 crc_poly_reg == ($past(mode_reg.crc_ansi) ? SIC_POLY_ANSI : SIC_POLY_CCITT);
    endproperty
    a_crc_sel: assert property (p_crc_sel) else $error("checksum polynomial mismatch");

    property p_reset_flag;
        @(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> mode_reg.reset_seen && mode_reg.word_size == SIC_RST_WSIZE && !mode_reg.crc_ansi;
    endproperty
    a_reset_flag: assert property (p_reset_flag) else $error("reset defaults wrong");

    property p_flag_hold;
        @(posedge aclk) disable iff (!aresetn)
        $fell(mode_reg.reset_seen) |-> $past(do_write && waddr_reg == SIC_OFF_MODE && !wdata_reg[SIC_POS_RESET]);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("reset flag cleared without a zero write");

    property p_timeout_rst;
        @(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> ##1 timeout_en_reg;
    endproperty
    a_timeout_rst: assert property (p_timeout_rst) else $error("timeout not enabled after reset");

    property p_frame_bits;
        @(posedge aclk) disable iff (!aresetn)
        $changed(mode_reg.word_size) |=> frame_word_bits_reg == sic_word_bits($past(mode_reg.word_size));
    endproperty
    a_frame_bits: assert property (p_frame_bits) else $error("frame word length not following setting");

    property p_ws_write;
        @(posedge aclk) disable iff (!aresetn)
        do_write && waddr_reg == SIC_OFF_MODE && wstrb_reg[1] |=> ##1 word_size_select_reg == $past(ws_next, 2);
    endproperty
    a_ws_write: assert property (p_ws_write) else $error("word size write not applied");

    c_write: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
    c_clear_flag: cover property (@(posedge aclk) disable iff (!aresetn) $fell(mode_reg.reset_seen));
    c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq_reg));
endmodule
`default_nettype wire

// ---- tb/sic_sample_src.sv ----
// converter-side model that feeds signed samples into the mode register block
// assumes the bench owns aclk and aresetn and gates the model with en
`timescale 1ns/1ps
`default_nettype none
module sic_sample_src (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        en,
    output logic [23:0]      sample,
    output logic             sample_valid
);
    integer     seed = 69;
    logic [3:0] n    = 4'h0;
    // one value every fourth cycle, full-scale corners mixed into the random ones
    always @(posedge aclk) begin
        n <= n + 4'h1;
        if (!aresetn) begin
            sample_valid <= 1'b0;
            sample       <= 24'h0;
        end else if (!en || n[1:0] != 2'h0) begin
            sample_valid <= 1'b0;
            sample       <= ~sample; // no stale value between pulses
        end else begin
            sample_valid <= 1'b1;
            if (n[3:2] == 2'h0) sample <= 24'h800000;
            else if (n[3:2] == 2'h1) sample <= 24'h7fffff;
            else sample <= 24'($random(seed));
        end
    end
endmodule
`default_nettype wire

// ---- tb/sic_mode_regs_tb.sv ----
// self-checking bench for the serial interface mode register block
// assumes the bench is the only AXI4-Lite master and the sample model the only source
`timescale 1ns/1ps
`default_nettype none
module sic_mode_regs_tb
    import sic_pkg::*;
;
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, src_en = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd, last;
    logic [3:0]  wstrb = 4'h0, strb = 4'hf;
    logic        awready, wready, bvalid, arready, rvalid, word_valid_reg, irq_reg, timeout_en_reg;
    logic        sample_valid, pend = 1'b0;
    logic [1:0]  bresp, rresp, word_size_select_reg, rsp, ws_at;
    logic [1:0]  exp_ws = 2'h1; // word size the stimulus has written, not read back from the design
    logic [15:0] crc_poly_reg;
    logic [5:0]  frame_word_bits_reg;
    logic [23:0] sample;
    sic_word_s   word_reg;
    int          miscompares = 0, n_compared = 0, cycles = 0;

    sic_mode_regs i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sample(sample),
        .sample_valid(sample_valid), .crc_poly_reg(crc_poly_reg), .timeout_en_reg(timeout_en_reg),
        .word_size_select_reg(word_size_select_reg), .frame_word_bits_reg(frame_word_bits_reg),
        .word_reg(word_reg), .word_valid_reg(word_valid_reg), .irq_reg(irq_reg));
    sic_sample_src i_src (.aclk(aclk), .aresetn(aresetn), .en(src_en), .sample(sample),
        .sample_valid(sample_valid));

    always #5 aclk = ~aclk;

    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [31:0] fmt(input logic [1:0] ws, input logic [23:0] s);
        case (ws)
            2'h0:    fmt = {16'h0, s[23:8]};
            2'h1:    fmt = {8'h0, s};
            2'h2:    fmt = {s, 8'h0};
            default: fmt = {{8{s[23]}}, s};
        endcase
    endfunction
    function automatic logic [31:0] bits_of(input logic [1:0] ws);
        bits_of = (ws == 2'h0) ? 32'h10 : (ws == 2'h1) ? 32'h18 : 32'h20;
    endfunction
    // both channels offered together, each dropped at its own take, response last
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        @(posedge aclk);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= strb; wvalid <= 1'b1; bready <= 1'b1;
        aw_ok = 0;
        w_ok = 0;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1) begin aw_ok = 1; awvalid <= 0; end
            if (!w_ok && wready === 1'b1) begin w_ok = 1; wvalid <= 0; end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        rsp = bresp;
        bready <= 0;
    endtask
    task automatic rd_(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rd = rdata;
        rsp = rresp;
        rready <= 0;
    endtask
    task automatic wait_c(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // every formatted word is judged against the sample and code seen one cycle before
    always @(posedge aclk) begin
        pend <= aresetn && sample_valid === 1'b1;
        last <= {8'h0, sample};
        ws_at <= exp_ws;
        if (pend) begin
            chk32("word_valid", 32'h1, {31'h0, word_valid_reg});
            chk32("word_data", fmt(ws_at, last[23:0]), word_reg.data);
            chk32("word_bits", bits_of(ws_at), {26'h0, word_reg.bits});
        end
    end
    // hang guard, well above the few hundred cycles the tests take
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    initial begin
        wait_c(2);
        aresetn <= 1;
        rd_(SIC_OFF_MODE); chk32("mode", 32'h0510, rd);
        rd_(SIC_OFF_STATUS); chk32("status", 32'h0b, rd);
        chk32("poly", 32'h1021, {16'h0, crc_poly_reg});
        chk32("timeout", 32'h1, {31'h0, timeout_en_reg});
        chk32("fbits", 32'h18, {26'h0, frame_word_bits_reg});
        rd_(SIC_OFF_IRQ_STAT); chk32("irq_stat", 32'h1, rd);
        rd_(SIC_OFF_IRQ_EN); chk32("irq_en", 32'h0, rd);
        $display("test reset_values done");
        // reserved bits always written as zero by this master
        wr(SIC_OFF_MODE, 32'h0c00); chk_resp("bresp", SIC_RESP_OKAY, rsp);
        wait_c(2);
        chk32("poly", 32'h8005, {16'h0, crc_poly_reg});
        chk32("timeout", 32'h0, {31'h0, timeout_en_reg});
        rd_(SIC_OFF_MODE); chk32("mode", 32'h0c00, rd);
        rd_(SIC_OFF_STATUS); chk32("status", 32'h18, rd);
        wr(SIC_OFF_MODE, 32'h0810);
        rd_(SIC_OFF_MODE); chk32("mode", 32'h0810, rd);
        rd_(SIC_OFF_STATUS); chk32("status", 32'h11, rd);
        wr(SIC_OFF_MODE, 32'h0010); wait_c(2);
        chk32("poly", 32'h1021, {16'h0, crc_poly_reg});
        $display("test mode_fields done");
        for (int ws = 0; ws < 4; ws++) begin
            exp_ws <= ws[1:0];
            wr(SIC_OFF_MODE, {22'h0, ws[1:0], 8'h10}); wait_c(2);
            chk32("fbits", bits_of(ws[1:0]), {26'h0, frame_word_bits_reg});
            chk32("ws_sel", {30'h0, ws[1:0]}, {30'h0, word_size_select_reg});
            src_en <= 1; wait_c(40); src_en <= 0; wait_c(3);
        end
        $display("test word_formats done");
        wr(SIC_OFF_IRQ_CLR, 32'h7); rd_(SIC_OFF_IRQ_STAT); chk32("irq_stat", 32'h0, rd);
        rd_(SIC_OFF_IRQ_CLR); chk32("irq_clr", 32'h0, rd);
        wr(SIC_OFF_IRQ_EN, 32'h4); wait_c(3); chk32("irq", 32'h0, {31'h0, irq_reg});
        src_en <= 1; wait_c(10); src_en <= 0; wait_c(3); chk32("irq", 32'h1, {31'h0, irq_reg});
        rd_(SIC_OFF_IRQ_STAT); chk32("irq_stat", 32'h4, rd);
        wr(SIC_OFF_IRQ_EN, 32'h2); wait_c(3); chk32("irq", 32'h0, {31'h0, irq_reg});
        wr(SIC_OFF_MODE, 32'h0110); wait_c(3); chk32("irq", 32'h1, {31'h0, irq_reg});
        wr(SIC_OFF_IRQ_CLR, 32'h7); wait_c(3); chk32("irq", 32'h0, {31'h0, irq_reg});
        $display("test interrupts done");
        wr(SIC_OFF_STATUS, 32'h0); chk_resp("bresp", SIC_RESP_SLVERR, rsp);
        wr(8'h14, 32'h5); chk_resp("bresp", SIC_RESP_SLVERR, rsp);
        rd_(8'h14); chk_resp("rresp", SIC_RESP_SLVERR, rsp); chk32("rdata", 32'h0, rd);
        rd_(SIC_OFF_MODE); chk32("mode", 32'h0110, rd);
        // lane 0 only: the upper byte of the mode word must not move
        strb <= 4'h1;
        wr(SIC_OFF_MODE, 32'h0b00); rd_(SIC_OFF_MODE); chk32("mode", 32'h0100, rd);
        strb <= 4'hf;
        $display("test refusals done");
        aresetn <= 0; wait_c(2); aresetn <= 1;
        rd_(SIC_OFF_MODE); chk32("mode", 32'h0510, rd);
        rd_(SIC_OFF_IRQ_STAT); chk32("irq_stat", 32'h1, rd);
        $display("test second_reset done");
        finish_test();
    end
endmodule
`default_nettype wire
